//--- rtl/wiper_ctl_params.svh
// Constants for the wiper register control block.
`ifndef WIPER_CTL_PARAMS_SVH
`define WIPER_CTL_PARAMS_SVH
`define WREG_W 8
`define CMD_NOP 5'h00
`define CMD_WR_WIPER 5'h01
`define CMD_WR_INPUT 5'h02
`define CMD_READBACK 5'h03
`define CMD_LIN_INC 5'h04
`define CMD_LIN_DEC 5'h05
`define CMD_DB_INC 5'h06
`define CMD_DB_DEC 5'h07
`define CMD_COPY_IN 5'h08
`define CMD_NV_STORE 5'h09
`define CMD_NV_LOAD 5'h0a
`define CMD_WR_NV 5'h0b
`define CMD_TOP_SCALE 5'h0c
`define CMD_BOT_SCALE 5'h0d
`define CMD_SOFT_RESET 5'h0e
`define CMD_SHUTDOWN 5'h0f
`define CMD_WR_CTRL 5'h10
`define CTL_WWE 0
`define CTL_NVE 1
`define CTL_LGS 2
`define CTL_BURST 3
`define CTL_RESET 4'h3
`define SEL_IN 2'h0
`define SEL_NV 2'h1
`define SEL_CTL 2'h2
`define SEL_WIPER 2'h3
`define MIDSCALE 8'h80
`define SYNC_IDLE 5'h0f
`define RELOAD_NS 30000
`define CLK_NS 10
`define RELOAD_CYC ((`RELOAD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- rtl/wiper_ctl_pkg.sv
// Types shared by the wiper register control block.
package wiper_ctl_pkg;
    typedef struct packed {
        logic [4:0] code;
        logic all_ch;
        logic second;
        logic [7:0] data;
    } cmd_s;
    typedef enum logic [1:0] {ST_IDLE, ST_RELOAD} ctl_state_e;
endpackage

//--- rtl/wiper_step.sv
// Step arithmetic for one wiper register value.
`timescale 1ns/10ps
`default_nettype none
`include "wiper_ctl_params.svh"
module wiper_step
    import wiper_ctl_pkg::*;
#(
    parameter int W = `WREG_W
) (
    input wire logic [4:0] code, // Command code.
    input wire logic [W-1:0] cur, // Present wiper value.
    output logic [W-1:0] nxt // Value after the step.
);
    // Linear steps saturate; dB steps shift with the documented end cases.
    always_comb begin
        nxt = cur;
        case (code)
            `CMD_LIN_INC: begin
                if (cur != {W{1'b1}}) begin
                    nxt = cur + 1'b1;
                end
            end
            `CMD_LIN_DEC: begin
                if (cur != '0) begin
                    nxt = cur - 1'b1;
                end
            end
            `CMD_DB_INC: begin
                if (cur == '0) begin
                    nxt = {{(W-1){1'b0}}, 1'b1};
                end else if (cur[W-1]) begin
                    nxt = {W{1'b1}};
                end else begin
                    nxt = {cur[W-2:0], 1'b0};
                end
            end
            `CMD_DB_DEC: begin
                nxt = {1'b0, cur[W-1:1]};
            end
            default: begin
                nxt = cur;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- rtl/wiper_register_control.sv
// Control, input and wiper registers of a single-channel potentiometer.
`timescale 1ns/10ps
`default_nettype none
`include "wiper_ctl_params.svh"
module wiper_register_control
    import wiper_ctl_pkg::*;
#(
    parameter int W = `WREG_W,
    parameter int RELOAD_CYCLES = `RELOAD_CYC
) (
    input wire logic clock, // System clock, 100 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic cmd_valid, // One-cycle pulse: command byte pair.
    input wire cmd_s cmd, // Decoded command from the serial front end.
    input wire logic burst_byte, // Pulse: extra data byte in burst.
    input wire logic [7:0] burst_data, // Data of the extra byte.
    input wire logic frame_start, // Pulse: start or repeated start.
    input wire logic reset_pin_n, // Hardware reset pin, active low.
    input wire logic transfer_strobe_n, // Input transfer strobe pin.
    input wire logic write_protect_n, // Hardware write protect pin.
    input wire logic independent_mode_strap, // Mode strap pin.
    input wire logic [W-1:0] nv_lower, // Stored lower string value.
    input wire logic [W-1:0] nv_upper, // Stored upper string value.
    output logic nv_store, // Pulse: store wiper or written data into memory.
    output logic [W-1:0] nv_store_data, // Data for the store.
    output logic [1:0] nv_store_slot, // 0 lower, 1 upper string.
    output logic [7:0] read_data, // Readback data.
    output logic busy, // High while a reload runs.
    output logic [3:0] control_config, // Control register.
    output logic linear_mode, // Effective linear gain mode.
    output logic [W-1:0] lower_string_resistor, // Wiper register 0.
    output logic [W-1:0] upper_string_resistor, // Wiper register 1.
    output logic top_scale, // Top scale position active.
    output logic bottom_scale, // Bottom scale position active.
    output logic shutdown // Shutdown state.
);
    localparam int CW = $clog2(RELOAD_CYCLES + 1);

    // Pin synchronisers; only the second stage is read. Reset loads the
    // idle pin levels so that no false falling edge follows reset.
    logic [4:0] s1_r, s2_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r <= `SYNC_IDLE;
            s2_r <= `SYNC_IDLE;
        end else begin
            s1_r <= {independent_mode_strap, write_protect_n,
                     transfer_strobe_n, reset_pin_n, 1'b1};
            s2_r <= s1_r;
        end
    end
    logic rst_pin_s, strobe_s, wp_s, strap_s;
    assign rst_pin_s = s2_r[1];
    assign strobe_s = s2_r[2];
    assign wp_s = s2_r[3];
    assign strap_s = s2_r[4];

    // State of the register file.
    ctl_state_e st_r, st_nxt;
    logic [3:0] ctl_r, ctl_nxt;
    logic [W-1:0] wip_r [2], wip_nxt [2];
    logic [W-1:0] inp_r [2], inp_nxt [2];
    logic ts_r, ts_nxt, bs_r, bs_nxt, sd_r, sd_nxt;
    logic prot_r, prot_nxt, strobe_d_r, strobe_d_nxt;
    logic init_r, init_nxt, strap_r, strap_nxt, rstp_d_r, rstp_d_nxt;
    logic burst_act_r, burst_act_nxt;
    cmd_s bcmd_r, bcmd_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic nvs_r, nvs_nxt;
    logic [W-1:0] nvd_r, nvd_nxt;
    logic [1:0] nvsl_r, nvsl_nxt;

    // Command in effect this cycle: a fresh one, or a burst repeat.
    cmd_s ex;
    logic ex_go;
    always_comb begin
        ex = cmd;
        ex_go = cmd_valid;
        if (!cmd_valid && burst_byte && burst_act_r) begin
            ex = bcmd_r;
            ex.data = burst_data;
            ex_go = 1'b1;
        end
    end

    // Channel hit: all channels or the selected string, with channel 1 reachable only in linear mode.
    function automatic logic hit(input cmd_s c, input int ch,
                                 input logic lin);
        if (c.all_ch) begin
            hit = (ch == 0) || lin;
        end else begin
            hit = (ch == 0) ? !c.second : (c.second && lin);
        end
    endfunction

    logic [W-1:0] stepped [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_step
            wiper_step #(.W(W)) u_step (
                .code(ex.code),
                .cur(wip_r[g]),
                .nxt(stepped[g])
            );
        end
    endgenerate

    logic lin, wlock, nvlock;
    assign lin = strap_r | ctl_r[`CTL_LGS];
    assign wlock = !ctl_r[`CTL_WWE] || prot_r;
    assign nvlock = !ctl_r[`CTL_NVE] || prot_r;

    // Next-state logic for commands, pins and reloads.
    always_comb begin
        st_nxt = st_r;
        ctl_nxt = ctl_r;
        wip_nxt = wip_r;
        inp_nxt = inp_r;
        ts_nxt = ts_r;
        bs_nxt = bs_r;
        sd_nxt = sd_r;
        strobe_d_nxt = strobe_s;
        rstp_d_nxt = rst_pin_s;
        init_nxt = init_r;
        strap_nxt = strap_r;
        burst_act_nxt = burst_act_r;
        bcmd_nxt = bcmd_r;
        cnt_nxt = cnt_r;
        rd_nxt = rd_r;
        nvs_nxt = 1'b0;
        nvd_nxt = nvd_r;
        nvsl_nxt = nvsl_r;
        // Protection changes only between commands.
        prot_nxt = ex_go ? prot_r : !wp_s;
        // The strap follows the pin until the first reload ends, so the
        // captured level comes from a settled synchroniser.
        if (!init_r) begin
            strap_nxt = strap_s;
        end
        if (frame_start) begin
            burst_act_nxt = 1'b0;
        end
        if (st_r == ST_RELOAD) begin
            if (cnt_r == '0) begin
                st_nxt = ST_IDLE;
                init_nxt = 1'b1;
                wip_nxt[0] = nv_lower;
                wip_nxt[1] = nv_upper;
                inp_nxt[0] = nv_lower;
                inp_nxt[1] = nv_upper;
                ts_nxt = 1'b0;
                bs_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end else if (ex_go) begin
            if (ctl_r[`CTL_BURST] && cmd_valid) begin
                burst_act_nxt = 1'b1;
                bcmd_nxt = cmd;
            end
            case (ex.code)
                `CMD_WR_WIPER, `CMD_WR_INPUT, `CMD_COPY_IN: begin
                    for (int i = 0; i < 2; i++) begin
                        if (hit(ex, i, lin) && (ex.code == `CMD_WR_INPUT
                            || !wlock)) begin
                            if (ex.code == `CMD_COPY_IN) begin
                                wip_nxt[i] = inp_r[i];
                            end else begin
                                inp_nxt[i] = ex.data[W-1:0];
                                if (ex.code == `CMD_WR_WIPER) begin
                                    wip_nxt[i] = ex.data[W-1:0];
                                end
                            end
                            if (ex.code != `CMD_WR_INPUT) begin
                                ts_nxt = 1'b0;
                                bs_nxt = 1'b0;
                            end
                        end
                    end
                end
                `CMD_LIN_INC, `CMD_DB_INC,
                `CMD_LIN_DEC, `CMD_DB_DEC: begin
                    for (int i = 0; i < 2; i++) begin
                        if (hit(ex, i, lin) && !wlock) begin
                            wip_nxt[i] = stepped[i];
                            inp_nxt[i] = stepped[i];
                            ts_nxt = 1'b0;
                            bs_nxt = 1'b0;
                        end
                    end
                end
                `CMD_READBACK: begin
                    case (ex.data[1:0])
                        `SEL_IN: rd_nxt = 8'(inp_r[ex.second & lin]);
                        `SEL_CTL: rd_nxt = {4'h0, ctl_r};
                        `SEL_WIPER: rd_nxt = 8'(wip_r[ex.second & lin]);
                        default: rd_nxt = 8'((ex.second & lin) ?
                                             nv_upper : nv_lower);
                    endcase
                end
                `CMD_NV_STORE: begin
                    if (!nvlock) begin
                        nvs_nxt = 1'b1;
                        nvd_nxt = wip_r[ex.second & lin];
                        nvsl_nxt = {1'b0, ex.second & lin};
                    end
                end
                `CMD_WR_NV: begin
                    if (!nvlock) begin
                        nvs_nxt = 1'b1;
                        nvd_nxt = ex.data[W-1:0];
                        nvsl_nxt = {1'b0, ex.second & lin};
                    end
                end
                `CMD_NV_LOAD: begin
                    // Allowed even while protected.
                    wip_nxt[0] = nv_lower;
                    inp_nxt[0] = nv_lower;
                    if (lin) begin
                        wip_nxt[1] = nv_upper;
                        inp_nxt[1] = nv_upper;
                    end
                    ts_nxt = 1'b0;
                    bs_nxt = 1'b0;
                end
                `CMD_TOP_SCALE: begin
                    ts_nxt = ex.data[0];
                    bs_nxt = bs_r & !ex.data[0];
                end
                `CMD_BOT_SCALE: begin
                    bs_nxt = ex.data[0];
                    ts_nxt = ts_r & !ex.data[0];
                end
                `CMD_SOFT_RESET: begin
                    st_nxt = ST_RELOAD;
                    cnt_nxt = CW'(RELOAD_CYCLES - 1);
                    ctl_nxt[`CTL_BURST] = 1'b0;
                    burst_act_nxt = 1'b0;
                end
                `CMD_SHUTDOWN: begin
                    sd_nxt = ex.data[0];
                    ts_nxt = 1'b0;
                    bs_nxt = 1'b0;
                end
                `CMD_WR_CTRL: begin
                    ctl_nxt = ex.data[3:0];
                end
                default: begin
                    rd_nxt = rd_r;
                end
            endcase
        end else if (strobe_d_r && !strobe_s && !wlock) begin
            // Strobe edge only counts when no command runs this cycle.
            wip_nxt = inp_r;
            ts_nxt = 1'b0;
            bs_nxt = 1'b0;
        end
        if (rstp_d_r && !rst_pin_s) begin
            st_nxt = ST_RELOAD;
            cnt_nxt = CW'(RELOAD_CYCLES - 1);
            ctl_nxt[`CTL_BURST] = 1'b0;
            burst_act_nxt = 1'b0;
        end
    end

    // Registers; reset loads the factory midscale as a safe value.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_RELOAD;
            ctl_r <= `CTL_RESET;
            wip_r <= '{`MIDSCALE, `MIDSCALE};
            inp_r <= '{`MIDSCALE, `MIDSCALE};
            ts_r <= 1'b0;
            bs_r <= 1'b0;
            sd_r <= 1'b0;
            prot_r <= 1'b0;
            strobe_d_r <= 1'b1;
            rstp_d_r <= 1'b1;
            init_r <= 1'b0;
            strap_r <= 1'b0;
            burst_act_r <= 1'b0;
            bcmd_r <= '0;
            cnt_r <= CW'(RELOAD_CYCLES - 1);
            rd_r <= 8'h00;
            nvs_r <= 1'b0;
            nvd_r <= '0;
            nvsl_r <= 2'h0;
        end else begin
            st_r <= st_nxt;
            ctl_r <= ctl_nxt;
            wip_r <= wip_nxt;
            inp_r <= inp_nxt;
            ts_r <= ts_nxt;
            bs_r <= bs_nxt;
            sd_r <= sd_nxt;
            prot_r <= prot_nxt;
            strobe_d_r <= strobe_d_nxt;
            rstp_d_r <= rstp_d_nxt;
            init_r <= init_nxt;
            strap_r <= strap_nxt;
            burst_act_r <= burst_act_nxt;
            bcmd_r <= bcmd_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            nvs_r <= nvs_nxt;
            nvd_r <= nvd_nxt;
            nvsl_r <= nvsl_nxt;
        end
    end

    // Outputs come from flip-flops; busy and linear_mode are decoded from them.
    assign nv_store = nvs_r;
    assign nv_store_data = nvd_r;
    assign nv_store_slot = nvsl_r;
    assign read_data = rd_r;
    assign busy = (st_r == ST_RELOAD);
    assign control_config = ctl_r;
    assign linear_mode = lin;
    assign lower_string_resistor = wip_r[0];
    assign upper_string_resistor = wip_r[1];
    assign top_scale = ts_r;
    assign bottom_scale = bs_r;
    assign shutdown = sd_r;

    AST_LOCK_WIPER: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_valid && cmd.code == `CMD_WR_WIPER && wlock && !busy)
        |=> $stable(wip_r[0])) else $error("locked wiper changed");
    AST_NV_LOCK: assert property (@(posedge clock) disable iff (!resetn)
        nvlock |=> !nv_store) else $error("store while locked");
    AST_MODE_OR: assert property (@(posedge clock) disable iff (!resetn)
        linear_mode == (strap_r | control_config[`CTL_LGS]))
        else $error("mode not OR");
    AST_WRITE_INPUT: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_valid && cmd.code == `CMD_WR_INPUT && !cmd.second
         && !cmd.all_ch && !busy && !(rstp_d_r && !rst_pin_s))
        |=> inp_r[0] == $past(cmd.data)) else $error("input write");
    AST_SHUTDOWN: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_valid && cmd.code == `CMD_SHUTDOWN && !busy)
        |=> shutdown == $past(cmd.data[0]) && $stable(wip_r[0]))
        else $error("shutdown");
    AST_SCALE_KEEP: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_valid && cmd.code == `CMD_TOP_SCALE && !busy)
        |=> $stable(wip_r[0]) && top_scale == $past(cmd.data[0]))
        else $error("scale changed wiper");
    AST_RELOAD: assert property (@(posedge clock) disable iff (!resetn)
        (st_r == ST_RELOAD && cnt_r == '0 && !(rstp_d_r && !rst_pin_s))
        |=> !busy && wip_r[0] == $past(nv_lower)) else $error("reload");
    AST_BURST_CLR: assert property (@(posedge clock) disable iff (!resetn)
        (cmd_valid && cmd.code == `CMD_SOFT_RESET && !busy)
        |=> !control_config[`CTL_BURST] && busy) else $error("burst");
    AST_PROT_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        ex_go |=> prot_r == $past(prot_r)) else $error("protect mid cmd");
endmodule
`default_nettype wire

//--- tb/wiper_host.sv
// Host model that hands decoded commands to the wiper control block.
`timescale 1ns/10ps
`default_nettype none
module wiper_host
    import wiper_ctl_pkg::*;
(
    input wire logic clock, // Bench clock.
    output logic cmd_valid, // Command strobe.
    output cmd_s cmd, // Command fields.
    output logic burst_byte, // Extra burst byte strobe.
    output logic [7:0] burst_data, // Extra burst byte.
    output logic frame_start // Start or repeated start.
);
    // Idle values at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        burst_byte = 1'b0;
        burst_data = 8'h00;
        frame_start = 1'b0;
    end

    // Every command opens its own frame, so a running burst never swallows
    // it; released fields are inverted so a stale value cannot pass.
    task automatic send(input logic [4:0] c, input logic [7:0] d,
                        input logic s, input logic a);
        @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
        cmd_valid <= 1'b1;
        cmd <= '{code: c, all_ch: a, second: s, data: d};
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd <= cmd_s'(~cmd);
        #1;
    endtask

    // One further data byte inside the current burst frame.
    task automatic burst(input logic [7:0] d);
        @(posedge clock);
        burst_byte <= 1'b1;
        burst_data <= d;
        @(posedge clock);
        burst_byte <= 1'b0;
        burst_data <= ~d;
        #1;
    endtask
endmodule
`default_nettype wire

//--- tb/wiper_register_control_tb.sv
// Self-checking bench for the wiper register control block.
`timescale 1ns/10ps
`default_nettype none
`include "wiper_ctl_params.svh"
module wiper_register_control_tb
    import wiper_ctl_pkg::*;
;
    logic clock, resetn, reset_pin_n, transfer_strobe_n, write_protect_n;
    logic independent_mode_strap, cmd_valid, burst_byte, frame_start;
    logic nv_store, busy, linear_mode, top_scale, bottom_scale, shutdown;
    logic [7:0] nv_lower, nv_upper, burst_data, nv_store_data, read_data;
    logic [7:0] lower_string_resistor, upper_string_resistor;
    logic [3:0] control_config;
    logic [1:0] nv_store_slot;
    cmd_s cmd;
    int num_errors = 0;
    int compares = 0;
    int wl, wu, il, ctl, prot, lin;
    logic [31:0] seed;
    logic [7:0] d;

    // Short reload count keeps each reset to a few cycles.
    wiper_register_control #(.RELOAD_CYCLES(4)) i_dut (
        .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
        .burst_byte(burst_byte), .burst_data(burst_data),
        .frame_start(frame_start), .reset_pin_n(reset_pin_n),
        .transfer_strobe_n(transfer_strobe_n),
        .write_protect_n(write_protect_n),
        .independent_mode_strap(independent_mode_strap),
        .nv_lower(nv_lower), .nv_upper(nv_upper), .nv_store(nv_store),
        .nv_store_data(nv_store_data), .nv_store_slot(nv_store_slot),
        .read_data(read_data), .busy(busy), .control_config(control_config),
        .linear_mode(linear_mode),
        .lower_string_resistor(lower_string_resistor),
        .upper_string_resistor(upper_string_resistor),
        .top_scale(top_scale), .bottom_scale(bottom_scale),
        .shutdown(shutdown));

    wiper_host i_host (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd),
        .burst_byte(burst_byte), .burst_data(burst_data),
        .frame_start(frame_start));

    always #5 clock = ~clock;

    task automatic final_report();
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input int e);
        compares++;
        if (got !== e[7:0]) begin
            $display("mismatch at %0t: got %h want %h", $time, got, e[7:0]);
            num_errors++;
        end
    endtask

    // Xorshift source; only the low byte is used as data.
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Bounded wait for the reload to finish.
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (busy !== 1'b0) begin
            $display("mismatch at %0t: busy stuck", $time);
            num_errors++;
            final_report();
        end
    endtask

    task automatic do_reset();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        #1;
        idle();
        wl = nv_lower;
        wu = nv_upper;
        il = nv_lower;
        ctl = 3;
    endtask

    // Sends one command, steps the model alike and compares the registers.
    task automatic run(input logic [4:0] c, input logic [7:0] v,
                       input logic s = 1'b0, input logic a = 1'b0);
        int w, ok;
        w = s ? wu : wl;
        ok = ctl[0] && !prot;
        i_host.send(c, v, s, a);
        if (ok) begin
            case (c)
                `CMD_WR_WIPER: w = v;
                `CMD_LIN_INC: w = (w == 255) ? w : w + 1;
                `CMD_LIN_DEC: w = (w == 0) ? w : w - 1;
                `CMD_DB_INC: w = (w == 0) ? 1 : (w >= 128) ? 255 : w * 2;
                `CMD_DB_DEC: w = w / 2;
                `CMD_COPY_IN: w = il;
                default: ;
            endcase
        end
        if (c == `CMD_NV_LOAD)
            w = s ? nv_upper : nv_lower;
        if (c == `CMD_WR_INPUT)
            il = v;
        if (c == `CMD_WR_CTRL)
            ctl = v[3:0];
        if (s)
            wu = w;
        else
            wl = w;
        if (!s && (c == `CMD_NV_LOAD || ok && c inside {1, [4:8]}))
            il = w;
        chk(lower_string_resistor, wl);
        if (lin)
            chk(upper_string_resistor, wu);
        chk({4'h0, control_config}, ctl);
        if (c == `CMD_READBACK)
            chk(read_data, v[1:0] == 0 ? il : v[1:0] == 1 ? nv_lower :
                v[1:0] == 2 ? ctl : wl);
    endtask

    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        reset_pin_n = 1'b1;
        transfer_strobe_n = 1'b1;
        write_protect_n = 1'b1;
        independent_mode_strap = 1'b0;
        seed = 32'h7fb2;
        nv_lower = rnd();
        nv_upper = rnd();
        prot = 0;
        lin = 0;
        do_reset();
        chk({4'h0, control_config}, 3);
        chk(lower_string_resistor, nv_lower);
        run(`CMD_WR_WIPER, rnd());
        run(`CMD_READBACK, 8'h00);
        run(`CMD_READBACK, 8'h03);
        run(`CMD_READBACK, 8'h01);
        run(`CMD_WR_INPUT, rnd());
        run(`CMD_READBACK, 8'h00);
        run(`CMD_COPY_IN, 8'h00);
        run(`CMD_WR_WIPER, 8'hff);
        run(`CMD_LIN_INC, 8'h01);
        run(`CMD_WR_WIPER, 8'h00);
        run(`CMD_LIN_DEC, 8'h00);
        for (int i = 0; i < 6; i++)
            run(i[0] ? `CMD_LIN_DEC : `CMD_LIN_INC, rnd(), 1'b0, i[1]);
        for (int i = 0; i < 18; i++)
            run(i < 9 ? `CMD_DB_INC : `CMD_DB_DEC, 8'h00);
        run(`CMD_TOP_SCALE, 8'h81);
        chk({7'h0, top_scale}, 1);
        run(`CMD_LIN_INC, 8'h01);
        chk({7'h0, top_scale}, 0);
        run(`CMD_BOT_SCALE, 8'h01);
        chk({7'h0, bottom_scale}, 1);
        run(`CMD_SHUTDOWN, 8'h01);
        chk({6'h0, bottom_scale, shutdown}, 1);
        run(`CMD_SHUTDOWN, 8'h00);
        chk({7'h0, shutdown}, 0);
        run(`CMD_WR_CTRL, 8'h00);
        run(`CMD_WR_WIPER, rnd());
        run(`CMD_NV_STORE, 8'h01);
        chk({7'h0, nv_store}, 0);
        run(`CMD_WR_CTRL, 8'h03);
        run(`CMD_NV_STORE, 8'h01);
        chk({7'h0, nv_store}, 1);
        chk(nv_store_data, wl);
        chk({6'h0, nv_store_slot}, 0);
        run(`CMD_WR_CTRL, 8'h07);
        chk({7'h0, linear_mode}, 1);
        lin = 1;
        run(`CMD_WR_WIPER, rnd(), 1'b1);
        run(`CMD_WR_CTRL, 8'h03);
        lin = 0;
        chk({7'h0, linear_mode}, 0);
        // Hardware transfer: the strobe is held low well past the sync delay.
        run(`CMD_WR_INPUT, rnd());
        @(posedge clock) transfer_strobe_n <= 1'b0;
        repeat (6) @(posedge clock);
        transfer_strobe_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        wl = il;
        chk(lower_string_resistor, wl);
        run(`CMD_WR_WIPER, ~nv_lower);
        @(posedge clock) write_protect_n <= 1'b0;
        repeat (6) @(posedge clock);
        prot = 1;
        run(`CMD_WR_WIPER, rnd());
        run(`CMD_NV_LOAD, 8'h00);
        @(posedge clock) write_protect_n <= 1'b1;
        repeat (6) @(posedge clock);
        prot = 0;
        run(`CMD_WR_CTRL, 8'h0b);
        run(`CMD_WR_WIPER, rnd());
        d = rnd();
        i_host.burst(d);
        chk(lower_string_resistor, d);
        wl = d;
        il = d;
        run(`CMD_READBACK, 8'h02);
        i_host.send(`CMD_SOFT_RESET, 8'h00, 1'b0, 1'b0);
        idle();
        chk(lower_string_resistor, nv_lower);
        chk({4'h0, control_config}, 3);
        // The reload brings the model back to the stored value.
        wl = nv_lower;
        il = nv_lower;
        ctl = 3;
        run(`CMD_WR_WIPER, ~nv_lower);
        @(posedge clock) reset_pin_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_pin_n <= 1'b1;
        idle();
        chk(lower_string_resistor, nv_lower);
        wl = nv_lower;
        il = nv_lower;
        run(`CMD_WR_CTRL, 8'h0b);
        @(posedge clock) independent_mode_strap <= 1'b1;
        do_reset();
        chk({7'h0, linear_mode}, 1);
        chk(upper_string_resistor, nv_upper);
        chk({4'h0, control_config}, 3);
        final_report();
    end
endmodule
`default_nettype wire
